// ===== design/dmem_decode.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Every sector is byte-wide RAM, read and written a whole byte at a time.
// - Locations 00H-7FH are the same registers in all sectors, except eeprom control, seen only in sector 1.
// - General RAM starts at 80H in each sector except sector 1, where it starts above the display bound; the space starts at 00H.
// - In sector 1, 80H up to the variant bound is display memory.
// - Display memory contents drive the display directly.
// - Pointer access takes the sector from the pointer high byte and location from its low byte.
// - Extended addresses have 13 bits: upper 5 bits sector, low byte location.
// - Unused special locations read 00H.
// - Read-only special bits ignore writes; others are read and write.
// - Plain direct access to the display range goes to sector 0 general RAM.
// - Indirect ports have no storage and act on the location their pointer holds.
// - Port 0 reaches sector 0 only; ports 1 and 2 reach any sector.
// - An indirect port reached indirectly reads 00H and ignores writes.
// - Bit set and clear change one bit of a byte and keep the rest.
module dmem_decode #(
  parameter int SECTORS = dmem_pkg::SECTORS_DEF,
  parameter logic [7:0] DISP_LAST = dmem_pkg::DISP_LAST_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Core request
  input wire logic req,
  input wire logic wr,
  input wire dmem_pkg::acc_mode_t mode,
  input wire logic [dmem_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire dmem_pkg::bit_op_t bit_op,
  input wire logic [2:0] bit_sel,
  // Core answer
  output logic ack,
  output logic [7:0] rdata,
  // Display drive and eeprom control
  output logic [7:0] disp_data [DISP_LAST - dmem_pkg::GP_BASE + 1],
  output logic [7:0] eeprom_ctrl
);
  localparam int DISP_N = DISP_LAST - dmem_pkg::GP_BASE + 1;
  typedef enum logic [1:0] {ST_IDLE, ST_RMW, ST_DONE} phase_t;
  typedef enum logic [1:0] {TGT_NONE, TGT_SFR, TGT_RAM, TGT_DISP} target_t;
  typedef struct packed {
    phase_t phase;
    target_t tgt;
    logic [7:0] sfr_rd;
    logic [7:0] loc;
    logic [7:0] sect;
    logic do_wr;
    logic [7:0] wval;
    logic ack;
    logic [7:0] rdata;
    logic [7:0] sector0_pointer;
    logic [7:0] pointer1_low;
    logic [7:0] pointer1_sector;
    logic [7:0] pointer2_low;
    logic [7:0] pointer2_sector;
    logic [7:0] status;
    logic [7:0] eeprom_ctrl_reg;
    logic [DISP_N*8-1:0] disp;
  } state_t;
  state_t s_reg;
  state_t s_next;
  dmem_if ram_port();
  logic [7:0] a_sect;
  logic [7:0] a_loc;
  logic indirect;
  logic [7:0] cur;
  logic [7:0] newv;
  logic [7:0] dsel;

  gp_ram #(.SECTORS(SECTORS)) u_ram (
    .core_clk(core_clk),
    .clk_en(clk_en),
    .port(ram_port)
  );

  // Resolve the effective sector and location of the request
  always_comb begin
    a_sect = {3'b000, addr[12:8]};
    a_loc = addr[7:0];
    indirect = 1'b0;
    if (mode == dmem_pkg::MODE_DIRECT) begin
      a_sect = 8'h00;
    end
    if (a_loc == dmem_pkg::IND0_ADDR) begin
      a_sect = 8'h00;
      a_loc = s_reg.sector0_pointer;
      indirect = 1'b1;
    end else if (a_loc == dmem_pkg::IND1_ADDR) begin
      a_sect = s_reg.pointer1_sector;
      a_loc = s_reg.pointer1_low;
      indirect = 1'b1;
    end else if (a_loc == dmem_pkg::IND2_ADDR) begin
      a_sect = s_reg.pointer2_sector;
      a_loc = s_reg.pointer2_low;
      indirect = 1'b1;
    end
  end

  // Read of the byte held at the resolved location, for RAM after the wait cycle
  always_comb begin
    dsel = s_reg.loc - dmem_pkg::GP_BASE;
    cur = dmem_pkg::ZERO_BYTE;
    if (s_reg.tgt == TGT_SFR) begin
      cur = s_reg.sfr_rd;
    end else if (s_reg.tgt == TGT_RAM) begin
      cur = ram_port.rdata;
    end else if (s_reg.tgt == TGT_DISP) begin
      cur = s_reg.disp[dsel*8 +: 8];
    end
    newv = s_reg.wval;
    if (bit_op == dmem_pkg::BOP_SET) begin
      newv = cur | (8'h01 << bit_sel);
    end else if (bit_op == dmem_pkg::BOP_CLR) begin
      newv = cur & ~(8'h01 << bit_sel);
    end
  end

  // Request sequencer: decode, read, then write back
  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    case (s_reg.phase)
      ST_IDLE: begin
        if (req) begin
          s_next.loc = a_loc;
          s_next.sect = a_sect;
          s_next.do_wr = wr;
          s_next.wval = wdata;
          s_next.sfr_rd = dmem_pkg::ZERO_BYTE;
          s_next.phase = ST_RMW;
          if (a_sect >= 8'(SECTORS)) begin
            s_next.tgt = TGT_NONE;
          end else if (a_loc >= dmem_pkg::GP_BASE) begin
            if (a_sect == dmem_pkg::DISP_SECTOR && a_loc <= DISP_LAST) begin
              s_next.tgt = TGT_DISP;
            end else begin
              s_next.tgt = TGT_RAM;
            end
          end else if (indirect && (a_loc == dmem_pkg::IND0_ADDR || a_loc == dmem_pkg::IND1_ADDR ||
                                    a_loc == dmem_pkg::IND2_ADDR)) begin
            s_next.tgt = TGT_NONE;
          end else begin
            s_next.tgt = TGT_SFR;
            if (a_loc == dmem_pkg::PTR0_ADDR) s_next.sfr_rd = s_reg.sector0_pointer;
            else if (a_loc == dmem_pkg::PTR1L_ADDR) s_next.sfr_rd = s_reg.pointer1_low;
            else if (a_loc == dmem_pkg::PTR1H_ADDR) s_next.sfr_rd = s_reg.pointer1_sector;
            else if (a_loc == dmem_pkg::PTR2L_ADDR) s_next.sfr_rd = s_reg.pointer2_low;
            else if (a_loc == dmem_pkg::PTR2H_ADDR) s_next.sfr_rd = s_reg.pointer2_sector;
            else if (a_loc == dmem_pkg::STAT_ADDR) s_next.sfr_rd = s_reg.status;
            else if (a_loc == dmem_pkg::EEC_ADDR && a_sect == dmem_pkg::DISP_SECTOR) begin
              s_next.sfr_rd = s_reg.eeprom_ctrl_reg;
            end else begin
              s_next.tgt = TGT_NONE;
            end
          end
        end
      end
      ST_RMW: begin
        s_next.rdata = cur;
        s_next.ack = 1'b1;
        s_next.phase = ST_DONE;
        if (s_reg.do_wr && s_reg.tgt == TGT_DISP) begin
          s_next.disp[dsel*8 +: 8] = newv;
        end
        if (s_reg.do_wr && s_reg.tgt == TGT_SFR) begin
          if (s_reg.loc == dmem_pkg::PTR0_ADDR) s_next.sector0_pointer = newv;
          else if (s_reg.loc == dmem_pkg::PTR1L_ADDR) s_next.pointer1_low = newv;
          else if (s_reg.loc == dmem_pkg::PTR1H_ADDR) s_next.pointer1_sector = newv;
          else if (s_reg.loc == dmem_pkg::PTR2L_ADDR) s_next.pointer2_low = newv;
          else if (s_reg.loc == dmem_pkg::PTR2H_ADDR) s_next.pointer2_sector = newv;
          else if (s_reg.loc == dmem_pkg::STAT_ADDR) begin
            s_next.status = (s_reg.status & dmem_pkg::STAT_RO_MASK) |
                            (newv & ~dmem_pkg::STAT_RO_MASK);
          end else if (s_reg.loc == dmem_pkg::EEC_ADDR) s_next.eeprom_ctrl_reg = newv;
        end
      end
      ST_DONE: begin
        s_next.phase = ST_IDLE;
      end
      default: begin
        s_next.phase = ST_IDLE;
      end
    endcase
  end

  // RAM sees the write in the read-modify-write cycle only; sectors past the array are refused before this
  always_comb begin
    ram_port.sector = (s_reg.phase == ST_RMW) ? s_reg.sect[dmem_pkg::SECT_W-1:0] :
                                                a_sect[dmem_pkg::SECT_W-1:0];
    ram_port.loc = (s_reg.phase == ST_RMW) ? s_reg.loc : a_loc;
    ram_port.wr = (s_reg.phase == ST_RMW) && s_reg.do_wr && (s_reg.tgt == TGT_RAM);
    ram_port.wdata = newv;
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flip-flops
  assign ack = s_reg.ack;
  assign rdata = s_reg.rdata;
  assign eeprom_ctrl = s_reg.eeprom_ctrl_reg;
  for (genvar i = 0; i < DISP_N; i++) begin : g_disp
    assign disp_data[i] = s_reg.disp[i*8 +: 8];
  end

  a_unused_reads_zero: assert property (@(posedge core_clk) disable iff (rst)
    (s_reg.ack && s_reg.tgt == TGT_NONE) |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ack_two_cycles: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && s_reg.phase == ST_IDLE && req) ##1 clk_en |=> ack)
    else $error("ack not after two cycles");
  a_status_ro_kept: assert property (@(posedge core_clk) disable iff (rst)
    clk_en |=> (s_reg.status & dmem_pkg::STAT_RO_MASK) == ($past(s_reg.status) & dmem_pkg::STAT_RO_MASK))
    else $error("read-only status bits changed");
  a_direct_sector0: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && req && s_reg.phase == ST_IDLE && mode == dmem_pkg::MODE_DIRECT && addr[7:0] >= 8'h80)
    |=> s_reg.tgt == TGT_RAM && s_reg.sect == 8'h00)
    else $error("direct display range not sector 0");
  a_port0_sector0: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && req && s_reg.phase == ST_IDLE && addr[7:0] == 8'h00) |=> s_reg.sect == 8'h00)
    else $error("port 0 left sector 0");
  a_big_sector_none: assert property (@(posedge core_clk) disable iff (rst)
    (s_reg.phase == ST_RMW && s_reg.sect >= 8'(SECTORS)) |-> s_reg.tgt == TGT_NONE)
    else $error("missing sector decoded");
  a_ram_no_write: assert property (@(posedge core_clk) disable iff (rst)
    (s_reg.tgt != TGT_RAM) |-> !ram_port.wr)
    else $error("stray ram write");
  a_refused_no_change: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && s_reg.phase == ST_RMW && s_reg.tgt == TGT_NONE) |=>
      (s_reg.disp == $past(s_reg.disp) && s_reg.status == $past(s_reg.status) &&
       s_reg.sector0_pointer == $past(s_reg.sector0_pointer) &&
       s_reg.pointer1_low == $past(s_reg.pointer1_low) &&
       s_reg.eeprom_ctrl_reg == $past(s_reg.eeprom_ctrl_reg)))
    else $error("refused access changed state");
  a_eec_sector1: assert property (@(posedge core_clk) disable iff (rst)
    (s_reg.phase == ST_RMW && s_reg.tgt == TGT_SFR && s_reg.loc == 8'h40) |-> s_reg.sect == 8'h01)
    else $error("eeprom control outside sector 1");
endmodule

// ===== design/dmem_if.sv
`timescale 1ns/1ps
interface dmem_if;
  logic wr;
  logic [dmem_pkg::SECT_W-1:0] sector;
  logic [7:0] loc;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport decoder (output wr, output sector, output loc, output wdata, input rdata);
  modport store (input wr, input sector, input loc, input wdata, output rdata);
endinterface

// ===== design/dmem_pkg.sv
package dmem_pkg;
  // Address space shape
  localparam int ADDR_W = 13;
  localparam int SECT_W = 5;
  localparam int LOC_W = 8;
  localparam int DATA_W = 8;
  // Special area ends just below general RAM
  localparam logic [7:0] GP_BASE = 8'h80;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] DISP_SECTOR = 8'h01;
  // Display upper bound, per variant: 98H, A4H or B0H
  localparam logic [7:0] DISP_LAST_DEF = 8'hB0;
  localparam int SECTORS_DEF = 17;
  // Special-function register locations
  localparam logic [7:0] IND0_ADDR = 8'h00;
  localparam logic [7:0] PTR0_ADDR = 8'h01;
  localparam logic [7:0] IND1_ADDR = 8'h02;
  localparam logic [7:0] PTR1L_ADDR = 8'h03;
  localparam logic [7:0] PTR1H_ADDR = 8'h04;
  localparam logic [7:0] IND2_ADDR = 8'h05;
  localparam logic [7:0] PTR2L_ADDR = 8'h06;
  localparam logic [7:0] PTR2H_ADDR = 8'h07;
  localparam logic [7:0] STAT_ADDR = 8'h0A;
  localparam logic [7:0] EEC_ADDR = 8'h40;
  // Reset values
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] EEC_RST = 8'h00;
  // Read-only bits of the status register (upper two)
  localparam logic [7:0] STAT_RO_MASK = 8'hC0;
  // Access modes
  typedef enum logic [1:0] {
    MODE_DIRECT,
    MODE_EXTENDED
  } acc_mode_t;
  // Bit operation kinds
  typedef enum logic [1:0] {
    BOP_NONE,
    BOP_SET,
    BOP_CLR
  } bit_op_t;
endpackage

// ===== design/gp_ram.sv
`timescale 1ns/1ps
module gp_ram #(
  parameter int SECTORS = dmem_pkg::SECTORS_DEF
) (
  // Clock
  input wire logic core_clk,
  input wire logic clk_en,
  // Access
  dmem_if.store port
);
  localparam int WORDS = SECTORS * 128;
  typedef struct packed {
    logic [7:0] rdata;
  } ram_state_t;
  logic [7:0] mem [WORDS];
  ram_state_t q_reg;
  ram_state_t q_next;
  logic [$clog2(WORDS)-1:0] idx;

  // Upper half of each sector holds 128 bytes
  always_comb begin
    idx = $clog2(WORDS)'({port.sector, port.loc[6:0]});
    q_next.rdata = mem[idx];
  end

  // Whole-byte storage, no reset on contents
  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      if (port.wr) begin
        mem[idx] <= port.wdata;
      end
      q_reg <= q_next;
    end
  end
  assign port.rdata = q_reg.rdata;
endmodule

// ===== tb/core_model.sv
`timescale 1ns/1ps
// Core side: one access at a time, held steady until the acknowledge edge
module core_model (
  // Clock and answer
  input wire logic core_clk,
  input wire logic ack,
  input wire logic [7:0] rdata,
  // Request
  output logic req,
  output logic wr,
  output dmem_pkg::acc_mode_t mode,
  output logic [dmem_pkg::ADDR_W-1:0] addr,
  output logic [7:0] wdata,
  output dmem_pkg::bit_op_t bit_op,
  output logic [2:0] bit_sel
);
  initial begin
    req = 1'b0;
    wr = 1'b0;
    mode = dmem_pkg::MODE_DIRECT;
    addr = 13'h0000;
    wdata = 8'h00;
    bit_op = dmem_pkg::BOP_NONE;
    bit_sel = 3'h0;
  end

  // Released address and data lines show the inverse so stale values cannot pass for live ones
  task automatic access(input logic w, input dmem_pkg::acc_mode_t m, input logic [12:0] a, input logic [7:0] d,
                        input dmem_pkg::bit_op_t b, input logic [2:0] bs, output logic [7:0] rd, output bit ok);
    int n;
    @(posedge core_clk);
    req <= 1'b1;
    wr <= w;
    mode <= m;
    addr <= a;
    wdata <= d;
    bit_op <= b;
    bit_sel <= bs;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 10);
    rd = rdata;
    ok = (ack === 1'b1);
    req <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    bit_op <= dmem_pkg::BOP_NONE;
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int NSECT = 17;
  localparam logic [7:0] DLAST = 8'hB0;
  localparam int DN = 49;
  localparam dmem_pkg::acc_mode_t DIR = dmem_pkg::MODE_DIRECT;
  localparam dmem_pkg::acc_mode_t EXT = dmem_pkg::MODE_EXTENDED;
  localparam dmem_pkg::bit_op_t NOP = dmem_pkg::BOP_NONE;
  // Ports of the design
  logic core_clk;
  logic rst;
  logic clk_en;
  logic req;
  logic wr;
  dmem_pkg::acc_mode_t mode;
  logic [12:0] addr;
  logic [7:0] wdata;
  dmem_pkg::bit_op_t bit_op;
  logic [2:0] bit_sel;
  logic ack;
  logic [7:0] rdata;
  logic [7:0] disp [DN];
  logic [7:0] eeprom_ctrl;
  // Reference: common registers, sparse byte memory
  logic [7:0] sfr [256];
  logic [7:0] mem [int];
  int miscompares;
  int n_tests;
  int cyc;
  int q [$];

  dmem_decode #(.SECTORS(NSECT), .DISP_LAST(DLAST)) DUT (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .req(req), .wr(wr), .mode(mode), .addr(addr), .wdata(wdata), .bit_op(bit_op), .bit_sel(bit_sel),
    .ack(ack), .rdata(rdata), .disp_data(disp), .eeprom_ctrl(eeprom_ctrl));
  core_model core (.core_clk(core_clk), .ack(ack), .rdata(rdata), .req(req), .wr(wr), .mode(mode),
    .addr(addr), .wdata(wdata), .bit_op(bit_op), .bit_sel(bit_sel));

  // Key of a resolved location: -1 none, 10000H+n common register, else sector*256+loc
  function automatic int res(int s, int l, bit ind);
    if (l < 128) begin
      if (l == 0 || l == 2 || l == 5) begin
        if (ind) return -1;
        if (l == 0) return res(0, sfr[1], 1);
        if (l == 2) return res(sfr[4], sfr[3], 1);
        return res(sfr[7], sfr[6], 1);
      end
      if (l == 8'h40 && s != 1) return -1;
      return 32'h1_0000 + l;
    end
    if (s >= NSECT || (s == 1 && l > DLAST)) return -1;
    return s * 256 + l;
  endfunction

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic op(bit w, dmem_pkg::acc_mode_t m, int a, logic [7:0] d, dmem_pkg::bit_op_t b = NOP, int bs = 0);
    int k;
    bit kn;
    bit ok;
    logic [7:0] old;
    logic [7:0] got;
    k = res(m == DIR ? 0 : (a >> 8) & 31, a & 255, 0);
    kn = !(k >= 0 && k < 32'h1_0000 && !mem.exists(k));
    old = k < 0 ? 8'h00 : (k >= 32'h1_0000 ? sfr[k - 32'h1_0000] : (kn ? mem[k] : 8'h00));
    core.access(w, m, a[12:0], d, b, bs[2:0], got, ok);
    chk("ack", 8'h01, {7'h00, ok});
    if (kn) chk("rdata", old, got);
    if (b == dmem_pkg::BOP_SET) d = old | (8'h01 << bs);
    if (b == dmem_pkg::BOP_CLR) d = old & ~(8'h01 << bs);
    if (w && (kn || b == NOP) && k >= 0) begin
      if (k < 32'h1_0000) mem[k] = d;
      else if (k == 32'h1_000A) sfr[10] = d & 8'h3F;
      else if (k inside {32'h1_0001, 32'h1_0003, 32'h1_0004, 32'h1_0006, 32'h1_0007, 32'h1_0040}) sfr[k & 255] = d;
    end
    // Outputs are registered; let them settle before looking
    repeat (2) @(negedge core_clk);
    if (k >= 384 && k <= 256 + DLAST && mem.exists(k)) chk("disp", mem[k], disp[k - 384]);
    chk("eeprom_ctrl", sfr[64], eeprom_ctrl);
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Ceiling well above the roughly two hundred accesses of the run
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    miscompares = 0;
    n_tests = 0;
    cyc = 0;
    foreach (sfr[i]) sfr[i] = 8'h00;
    void'($urandom(32'hd9d3));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    chk("eeprom_ctrl", 8'h00, eeprom_ctrl);
    // Common registers, read-only status bits, a gap, eeprom control in sector 1 only
    op(1, DIR, 13'h0001, 8'h85);
    op(1, EXT, 13'h050A, 8'hFF);
    op(0, DIR, 13'h000A, 8'h00);
    op(1, DIR, 13'h0020, 8'h5A);
    op(0, DIR, 13'h0020, 8'h00);
    op(1, EXT, 13'h0040, 8'h3C);
    op(1, EXT, 13'h0140, 8'hA5);
    op(0, DIR, 13'h0040, 8'h00);
    op(1, DIR, 13'h0000, 8'h77);
    op(0, EXT, 13'h0085, 8'h00);
    // Sector 1 picked through both pointer pairs, then display bytes
    op(1, DIR, 13'h0004, 8'h01);
    op(1, DIR, 13'h0007, 8'h01);
    for (int i = 8'h80; i <= 8'hB0; i += 8) begin
      op(1, DIR, 13'h0003, i[7:0]);
      op(1, DIR, 13'h0002, 8'($urandom));
      op(1, DIR, 13'h0006, i[7:0] - 8'h01);
      op(1, DIR, 13'h0005, 8'($urandom));
    end
    op(0, DIR, 13'h0002, 8'h00);
    op(1, DIR, 13'h0090, 8'h3E);
    chk("disp", mem[256 + 8'h90], disp[16]);
    op(0, EXT, 13'h0090, 8'h00);
    // Far sector through a pointer, then a port aimed at another port
    op(1, DIR, 13'h0004, 8'h03);
    op(1, DIR, 13'h0003, 8'h90);
    op(1, DIR, 13'h0002, 8'hC3);
    op(0, EXT, 13'h0390, 8'h00);
    op(1, DIR, 13'h0003, 8'h05);
    op(1, DIR, 13'h0002, 8'h11);
    op(0, DIR, 13'h0002, 8'h00);
    for (int s = 17; s < 32; s += 7) begin
      op(1, EXT, s * 256 + 8'h90, 8'h99);
      op(0, EXT, s * 256 + 8'h90, 8'h00);
    end
    // Single-bit set keeps the other bits; the clears hit sector 0 byte 85H, written earlier through port 0, and are checked
    op(1, EXT, 13'h02A0, 8'h5A);
    for (int b = 0; b < 8; b++) begin
      op(1, EXT, 13'h02A0, 8'h00, dmem_pkg::BOP_SET, b);
      op(1, DIR, 13'h0085, 8'h00, dmem_pkg::BOP_CLR, (b + 3) % 8);
    end
    op(0, EXT, 13'h02A0, 8'h00);
    // Clock enable dropped after the request is taken: the access must stall, then finish intact
    fork
      op(1, EXT, 13'h02A0, 8'h00, dmem_pkg::BOP_CLR, 4);
      begin
        repeat (2) @(posedge core_clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge core_clk);
        clk_en <= 1'b1;
      end
    join
    op(0, EXT, 13'h02A0, 8'h00);
    // Random general RAM traffic across sectors
    for (int n = 0; n < 60; n++) begin
      int s;
      s = $urandom % NSECT;
      if (s == 1) s = 0;
      q.push_back(s * 256 + 8'h80 + $urandom % 128);
      op(1, EXT, q[$], 8'($urandom));
    end
    foreach (q[i]) op(0, EXT, q[i], 8'h00);
    give_verdict();
  end
endmodule
